// ==== src/ppie_pkg.sv ====
// Shared constants, register map and types for the pin polarity / irq enable block
package ppie_pkg;

  // ==========================================================
  // Sizes
  localparam int NPORT = 5;                  // Interrupt-capable ports
  localparam int PW    = 8;                  // Pins per port
  localparam int AW    = 16;                 // AHB address bits decoded
  localparam int IW    = 14;                 // Register index bits

  typedef logic [NPORT-1:0][PW-1:0] ppie_grp_t;   // One bit per pin
  typedef logic [IW-1:0]            ppie_idx_t;   // Word index

  // ==========================================================
  // Register indices (byte address = 4 * index); port order:
  // 0 analog high, 1 analog low, 2 serial, 3 pwm, 4 highvolt
  localparam logic [NPORT-1:0][IW-1:0] IEN_IDX =
    {14'h0336, 14'h02F6, 14'h02D6, 14'h028D, 14'h028C};
  localparam logic [NPORT-1:0][IW-1:0] POL_IDX =
    {14'h0294, 14'h0293, 14'h0292, 14'h0291, 14'h0290};
  localparam logic [NPORT-1:0][IW-1:0] FLG_IDX =
    {14'h029C, 14'h029B, 14'h029A, 14'h0299, 14'h0298};

  // Implemented polarity bits per port
  localparam ppie_grp_t POL_IMPL = {8'h01, 8'hFF, 8'h0F, 8'hFF, 8'hFF};
  // Ports whose pin irqs also act as key wakeup
  localparam ppie_grp_t WAKE_GRP = {8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF};
  localparam ppie_grp_t GRP_ZERO = {NPORT{8'h00}};

  // CAN receive input location
  localparam logic [2:0] CAN_PORT = 3'h2;
  localparam logic [2:0] CAN_BIT  = 3'h0;

  // Edges after reset release before the mode strap is taken
  localparam logic [1:0] MODE_WAIT = 2'h3;
  localparam logic       HRESP_OKAY = 1'h0;
  localparam int         HTRANS_ACT = 1;     // htrans bit set for NONSEQ/SEQ

  // ==========================================================
  // Types
  typedef enum logic [1:0] {K_NONE, K_IEN, K_POL, K_FLG} ppie_kind_e;

  typedef struct packed {
    ppie_kind_e kind;
    logic [2:0] port;
  } ppie_slot_s;

  // Drivers competing for the serial port pins, highest first
  typedef struct packed {
    logic [PW-1:0] hi_oe;
    logic [PW-1:0] hi_d;
    logic [PW-1:0] lo_oe;
    logic [PW-1:0] lo_d;
    logic [PW-1:0] gp_oe;
    logic [PW-1:0] gp_d;
  } ppie_shared_s;

  typedef struct packed {
    logic          ph_v;
    logic          ph_w;
    ppie_idx_t     ph_idx;
    ppie_grp_t     ien;
    ppie_grp_t     pol;
    ppie_grp_t     flg;
    ppie_grp_t     s1;
    ppie_grp_t     s2;
    ppie_grp_t     s3;
    ppie_grp_t     stb;
    logic [2:0]    dbg_s;
    logic          dbg_stb;
    logic [1:0]    mode_cnt;
    logic          mode_done;
    logic          mode_sel;
    logic [31:0]   hrdata;
    logic          hready;
    logic          hresp;
    logic          irq;
    logic          wake;
    ppie_grp_t     pu;
    ppie_grp_t     pd;
    logic [PW-1:0] sp_out;
    logic [PW-1:0] sp_oe;
    logic          dbg_out;
    logic          dbg_oe;
  } ppie_state_s;

  localparam ppie_state_s ST_RST = '{hready: 1'b1, default: '0};

endpackage

// ==== src/ppie_top.sv ====
// Pin polarity, pin interrupt enable and shared-pin output logic
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
// How it works
// - Shared pin driven by highest enabled function
// - Debug pin: mode strap, then debug link
// - Polarity one pulldown, zero pullup
// - Polarity one rising, zero falling edge
// - CAN active: pulldown request disables pull
// - Unimplemented polarity bits read zero
// - Polarity registers readable and writable anytime
// - Per-port irq enables, reset to zero
// - Analog port pins give irq and wakeup
// - Flag on edge; irq needs flag and enable
module ppie_top (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [15:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  input  wire ppie_pkg::ppie_grp_t  pin_lvl,
  input  wire ppie_pkg::ppie_grp_t  pull_en,
  output logic                      pull_up,
  output logic                      pull_dn,
  input  wire logic                 can_active,
  input  wire ppie_pkg::ppie_shared_s shared_drv,
  output logic [7:0]                serial_pin_drv,
  output logic [7:0]                serial_pin_en,
  input  wire logic                 debug_comm_pin_lvl,
  output logic                      debug_comm_pin_drv,
  output logic                      debug_comm_pin_en,
  input  wire logic                 debug_link_drv,
  input  wire logic                 debug_link_en,
  output logic                      debug_link_rx,
  output logic                      mode_select_input,
  output logic                      mode_valid,
  output logic                      irq,
  output logic                      analog_port_key_wakeup
);
  import ppie_pkg::*;

  // ==========================================================
  // Helpers

  // Map a word index onto a register kind and port
  function automatic ppie_slot_s slot_of(input ppie_idx_t idx);
    ppie_slot_s s;
    s = '{kind: K_NONE, port: 3'h0};
    for (int p = 0; p < NPORT; p++) begin
      if (idx == IEN_IDX[p]) s = '{kind: K_IEN, port: 3'(p)};
      if (idx == POL_IDX[p]) s = '{kind: K_POL, port: 3'(p)};
      if (idx == FLG_IDX[p]) s = '{kind: K_FLG, port: 3'(p)};
    end
    return s;
  endfunction

  // Fixed priority pick: high, then low, then plain gpio
  function automatic logic [1:0] pick(input logic [5:0] c);
    logic [1:0] r;
    r = 2'h0;
    if (c[5])      r = {1'b1, c[4]};
    else if (c[3]) r = {1'b1, c[2]};
    else if (c[1]) r = {1'b1, c[0]};
    return r;
  endfunction

  // ==========================================================
  // State

  ppie_state_s r;        // Registered state
  ppie_state_s nx;       // Next state
  ppie_slot_s  ws;       // Write target
  ppie_slot_s  rs;       // Read target
  ppie_grp_t   clr;      // Flag clear mask from software
  ppie_grp_t   newv;     // Filtered pin level
  ppie_grp_t   set;      // Qualified edges this cycle
  ppie_grp_t   canm;     // Pin whose pulldown is vetoed

  // ==========================================================
  // Next state
  always_comb begin
    nx   = r;
    clr  = GRP_ZERO;
    canm = GRP_ZERO;
    ws   = slot_of(r.ph_idx);
    rs   = slot_of(haddr[AW-1:2]);

    // Data phase of a write; zero wait so it lands now
    if (r.ph_v && r.ph_w) begin
      case (ws.kind)
        K_IEN: nx.ien[ws.port] = hwdata[PW-1:0];
        K_POL: nx.pol[ws.port] = hwdata[PW-1:0] & POL_IMPL[ws.port];
        K_FLG: clr[ws.port] = hwdata[PW-1:0];
        default: begin
          // Unmapped: write ignored
        end
      endcase
    end

    // Three-stage sync; level counts once stages two and three agree
    nx.s1  = pin_lvl;
    nx.s2  = r.s1;
    nx.s3  = r.s2;
    newv   = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.stb);
    nx.stb = newv;

    // Edge select by polarity: one rising, zero falling
    set = (r.pol & newv & ~r.stb) | (~r.pol & ~newv & r.stb);

    // Set beats a same-cycle write-one clear
    nx.flg = (r.flg & ~clr) | set;

    // Level irq and analog-port key wakeup
    nx.irq  = |(nx.flg & nx.ien);
    nx.wake = |(nx.flg & nx.ien & WAKE_GRP);

    // Pull selection; CAN rx gets no pulldown while can_active is set
    if (can_active) canm[CAN_PORT][CAN_BIT] = 1'b1;
    nx.pu = pull_en & ~nx.pol;
    nx.pd = pull_en & nx.pol & ~canm;

    // Address phase capture; only word transfers are expected
    nx.ph_v   = hsel && hready && htrans[HTRANS_ACT];
    nx.ph_w   = hwrite;
    nx.ph_idx = haddr[AW-1:2];
    nx.hready = 1'b1;
    nx.hresp  = HRESP_OKAY;

    // Read data from next state so a prior write is visible
    nx.hrdata = 32'h0000_0000;
    if (nx.ph_v && !hwrite) begin
      case (rs.kind)
        K_IEN: nx.hrdata[PW-1:0] = nx.ien[rs.port];
        K_POL: nx.hrdata[PW-1:0] = nx.pol[rs.port];
        K_FLG: nx.hrdata[PW-1:0] = nx.flg[rs.port];
        default: begin
          // Unmapped: reads zero
        end
      endcase
    end

    // Shared serial pins: highest enabled function wins
    for (int i = 0; i < PW; i++) begin
      {nx.sp_oe[i], nx.sp_out[i]} = pick({shared_drv.hi_oe[i], shared_drv.hi_d[i],
                                          shared_drv.lo_oe[i], shared_drv.lo_d[i],
                                          shared_drv.gp_oe[i], shared_drv.gp_d[i]});
    end

    // Debug pin sync; stage zero feeds only stage one
    nx.dbg_s = {r.dbg_s[1:0], debug_comm_pin_lvl};
    if (r.dbg_s[1] == r.dbg_s[2]) nx.dbg_stb = r.dbg_s[2];

    // Strap taken after release, pin kept undriven until then
    if (!r.mode_done) begin
      if (r.mode_cnt == MODE_WAIT) begin
        nx.mode_done = 1'b1;
        nx.mode_sel  = r.dbg_s[2];
      end else begin
        nx.mode_cnt = r.mode_cnt + 2'h1;
      end
    end
    nx.dbg_oe  = r.mode_done & debug_link_en;
    nx.dbg_out = debug_link_drv;
  end

  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= ST_RST;
    end else begin
      r <= nx;
    end
  end

  // ==========================================================
  // Outputs from flops; pull_up and pull_dn are ORs of flops
  assign hreadyout              = r.hready;
  assign hrdata                 = r.hrdata;
  assign hresp                  = r.hresp;
  assign pull_up                = |r.pu;
  assign pull_dn                = |r.pd;
  assign serial_pin_drv         = r.sp_out;
  assign serial_pin_en          = r.sp_oe;
  assign debug_comm_pin_drv     = r.dbg_out;
  assign debug_comm_pin_en      = r.dbg_oe;
  assign debug_link_rx          = r.dbg_stb;
  assign mode_select_input      = r.mode_sel;
  assign mode_valid             = r.mode_done;
  assign irq                    = r.irq;
  assign analog_port_key_wakeup = r.wake;

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_irq_level: assert property (irq == |(r.flg & r.ien))
    else $error("irq not matching flags and enables");

  a_edge_rise: assert property ($rose(r.stb[0][0]) && $past(r.pol[0][0])
    |-> r.flg[0][0])
    else $error("rising edge did not set flag");

  a_edge_fall: assert property ($fell(r.stb[0][0]) && !$past(r.pol[0][0])
    |-> r.flg[0][0])
    else $error("falling edge did not set flag");

  a_pol_unimpl: assert property ((r.pol & ~POL_IMPL) == GRP_ZERO)
    else $error("unimplemented polarity bit set");

  a_pull_excl: assert property ((r.pu & r.pd) == GRP_ZERO)
    else $error("pullup and pulldown together");

  a_can_no_pd: assert property ($past(can_active) |-> !r.pd[CAN_PORT][CAN_BIT])
    else $error("pulldown on CAN receive while active");

  a_dbg_quiet: assert property (!r.mode_done |=> !debug_comm_pin_en)
    else $error("debug pin driven before strap taken");

  a_out_prio: assert property (serial_pin_en ==
    $past(shared_drv.hi_oe | shared_drv.lo_oe | shared_drv.gp_oe))
    else $error("shared pin enable wrong");

  // Every written one clears its flag unless an edge sets it again in that cycle
  a_flag_w1c: assert property (r.ph_v && r.ph_w && ws.kind == K_FLG
    |=> (r.flg[$past(ws.port)] & $past(hwdata[PW-1:0] & ~set[ws.port])) == 8'h00)
    else $error("flag not cleared by write one");

  a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus slave not ready or not okay");

  c_irq_rise: cover property ($rose(irq));
  c_pol_write: cover property (r.ph_v && r.ph_w && ws.kind == K_POL);
  c_flag_read: cover property (r.ph_v && !r.ph_w && r.hrdata != 32'h0000_0000);
  c_mode_done: cover property ($rose(r.mode_done));

endmodule

// ==== verification/ppie_far.sv ====
// Far-side model: pin levels, debug pin wire and mode strap driver
`timescale 1ns/1ps
module ppie_far (
  input  wire logic           dev_en,
  input  wire logic           dev_drv,
  output logic                pin_wire,
  output ppie_pkg::ppie_grp_t pin_lvl
);
  import ppie_pkg::*;
  // ==========================================================
  // Strap driver
  logic host_en;   // Host holds the debug pin through reset
  logic host_drv;  // Strap level; low differs from the pull-up
  initial begin
    host_en  = 1'b1;
    host_drv = 1'b0;
    pin_lvl  = GRP_ZERO;  // Pins low, so reset release makes no edge
  end
  // Released wire goes to its pull-up, never keeps a stale value
  assign pin_wire = dev_en ? dev_drv : (host_en ? host_drv : 1'b1);
  // Move one pin, called just after a clock edge
  task automatic set_pin(input int p, input int b, input logic v);
    pin_lvl[p][b] <= v;
  endtask
  // Let go of the strap once the mode is taken
  task automatic release_strap();
    host_en <= 1'b0;
  endtask
endmodule

// ==== verification/ppie_top_bench.sv ====
// Self-checking bench for the pin polarity and irq enable block
`timescale 1ns/1ps
module ppie_top_bench;
  import ppie_pkg::*;
  // ==========================================================
  // Signals
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;   // Active low
  logic         hsel = 1'b0;
  logic [15:0]  haddr = 16'h0000;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [2:0]   hsize = 3'h2;     // Whole words only
  logic [31:0]  hwdata = 32'h0;
  logic         hready;           // Slave's hreadyout looped back
  logic [31:0]  hrdata;
  logic         hresp;
  ppie_grp_t    pin_lvl;
  ppie_grp_t    pull_en = GRP_ZERO;
  logic         pull_up;
  logic         pull_dn;
  logic         can_active = 1'b0;
  ppie_shared_s shared_drv = '0;
  logic [7:0]   sp_drv;
  logic [7:0]   sp_en;
  logic         dbg_wire;
  logic         dbg_drv;
  logic         dbg_en;
  logic         link_drv = 1'b0;
  logic         link_en = 1'b0;
  logic         link_rx;
  logic         mode_sel;
  logic         mode_valid;
  logic         irq;
  logic         wake;
  logic [31:0]  rd;               // Last read word
  int           fails = 0;
  int           num_checks = 0;
  // 25 MHz clock
  always #20 hclk = ~hclk;
  ppie_top i_ppie_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .pin_lvl(pin_lvl),
    .pull_en(pull_en), .pull_up(pull_up), .pull_dn(pull_dn), .can_active(can_active),
    .shared_drv(shared_drv), .serial_pin_drv(sp_drv), .serial_pin_en(sp_en),
    .debug_comm_pin_lvl(dbg_wire), .debug_comm_pin_drv(dbg_drv),
    .debug_comm_pin_en(dbg_en), .debug_link_drv(link_drv), .debug_link_en(link_en),
    .debug_link_rx(link_rx), .mode_select_input(mode_sel), .mode_valid(mode_valid),
    .irq(irq), .analog_port_key_wakeup(wake));
  ppie_far i_ppie_far (.dev_en(dbg_en), .dev_drv(dbg_drv), .pin_wire(dbg_wire),
    .pin_lvl(pin_lvl));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One AHB single transfer; waits on hready, no assumed latency
  task automatic bus(input logic w, input ppie_idx_t idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {idx, 2'b00};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input string what, input ppie_idx_t idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(what, rd, exp);
  endtask
  task automatic close_out();
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    for (int p = 0; p < NPORT; p++) rchk("irq_enable_rst", IEN_IDX[p], 32'h0);
    rchk("unmapped", 14'h0100, 32'h0);
    chk("hresp", hresp, 1'b0);
    chk("mode", {mode_valid, mode_sel}, 2'b10);
  endtask
  // Polarity masks and enable read-back, any time
  task automatic t_regs();
    for (int p = 0; p < NPORT; p++) begin
      bus(1'b1, POL_IDX[p], 32'hFF);
      rchk("polarity", POL_IDX[p], {24'h0, POL_IMPL[p]});
      bus(1'b1, IEN_IDX[p], 32'h5A);
      rchk("irq_enable", IEN_IDX[p], 32'h5A);
      bus(1'b1, IEN_IDX[p], 32'h0);
    end
  endtask
  // One pulled pin; expected {pull_up, pull_dn}
  task automatic pull_case(input int p, input logic [7:0] pol, input logic can,
                           input logic [1:0] exp);
    ppie_grp_t pe;
    pe = GRP_ZERO;
    pe[p][0] = 1'b1;
    pull_en <= pe;
    can_active <= can;
    bus(1'b1, POL_IDX[p], {24'h0, pol});
    repeat (2) @(posedge hclk);
    chk("pull_up_dn", {pull_up, pull_dn}, {30'h0, exp});
  endtask
  // Edge flags, masking, clearing and wakeup on analog high bit 3
  task automatic t_edge();
    bus(1'b1, POL_IDX[0], 32'h08);
    i_ppie_far.set_pin(0, 3, 1'b1);
    repeat (5) @(posedge hclk);
    rchk("flag_rise", FLG_IDX[0], 32'h08);
    chk("irq_masked", irq, 1'b0);
    bus(1'b1, IEN_IDX[0], 32'h08);
    @(posedge hclk);
    chk("irq_on", {irq, wake}, 2'b11);
    i_ppie_far.set_pin(0, 3, 1'b0);
    repeat (5) @(posedge hclk);
    bus(1'b1, FLG_IDX[0], 32'h08);
    rchk("flag_clear", FLG_IDX[0], 32'h0);
    chk("irq_off", {irq, wake}, 2'b00);
    bus(1'b1, POL_IDX[0], 32'h00);
    i_ppie_far.set_pin(0, 3, 1'b1);
    repeat (5) @(posedge hclk);
    rchk("rise_ignored", FLG_IDX[0], 32'h0);
    i_ppie_far.set_pin(0, 3, 1'b0);
    repeat (5) @(posedge hclk);
    rchk("flag_fall", FLG_IDX[0], 32'h08);
    chk("irq_fall", irq, 1'b1);
  endtask
  // Bit 0 high wins, bit 1 low wins, bit 2 gpio only
  task automatic t_prio();
    shared_drv <= '{hi_oe: 8'h01, hi_d: 8'h00, lo_oe: 8'h03, lo_d: 8'h03,
                    gp_oe: 8'h07, gp_d: 8'h07};
    repeat (2) @(posedge hclk);
    chk("serial_en", sp_en, 8'h07);
    chk("serial_drv", sp_drv & sp_en, 8'h06);
  endtask
  // Debug link drives low, then lets the pull-up return
  task automatic t_debug();
    link_en <= 1'b1;
    repeat (6) @(posedge hclk);
    chk("debug_drive", {dbg_en, dbg_drv, link_rx}, 3'b100);
    link_en <= 1'b0;
    link_drv <= 1'b1;
    repeat (6) @(posedge hclk);
    chk("debug_release", {dbg_en, dbg_drv, link_rx}, 3'b011);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    t_reset();
    i_ppie_far.release_strap();
    t_regs();
    pull_case(0, 8'h00, 1'b0, 2'b10);
    pull_case(0, 8'h01, 1'b0, 2'b01);
    pull_case(2, 8'h01, 1'b1, 2'b00);
    pull_case(2, 8'h00, 1'b1, 2'b10);
    pull_case(2, 8'h01, 1'b0, 2'b01);
    pull_en <= GRP_ZERO;
    t_edge();
    t_prio();
    t_debug();
    close_out();
  end
  // Watchdog; the run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge hclk);
    fails++;
    close_out();
  end
endmodule
